// *** include/smc_params.svh ***
// constants of the stepper settings core: clock, codes, tables, thresholds
// assumes inclusion by smc_pkg, smc_core and the checker by bare name
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// ==========================================================
// clock
`define SMC_CLK_HZ 26'd20000000
// ==========================================================
// step mode codes
`define SMC_MODE_FULL 4'h0
`define SMC_MODE_HALF 4'h1
`define SMC_MODE_QUARTER 4'h2
`define SMC_MODE_FIFTH 4'h3
`define SMC_MODE_EIGHTH 4'h4
`define SMC_MODE_TENTH 4'h5
`define SMC_MODE_16TH 4'h6
`define SMC_MODE_32ND 4'h7
`define SMC_MODE_64TH 4'h8
`define SMC_MODE_ADAPT 4'h9
// finest internal unit: a full step is this many position counts
`define SMC_UNITS_PER_FULL 7'h40
`define SMC_HALF_STEP_UNITS 7'h20
// ==========================================================
// adaptive mode speed thresholds in rpm (64th below first, full above last)
`define SMC_RPM_T64 11'd60
`define SMC_RPM_T32 11'd120
`define SMC_RPM_T16 11'd250
`define SMC_RPM_T8 11'd500
`define SMC_RPM_T4 11'd1000
`define SMC_RPM_T2 11'd2000
`define SMC_SEC_PER_MIN 7'd60
// ==========================================================
// full steps per revolution by angle select; 1.8 degree is the default
`define SMC_ANGLE_1P8 3'h0
`define SMC_SPR_1P8 9'd200
`define SMC_SPR_0P9 9'd400
`define SMC_SPR_3P6 9'd100
`define SMC_SPR_7P5 9'd48
`define SMC_SPR_15 9'd24
// ==========================================================
// encoder line counts by select code
`define SMC_LINES_0 12'd500
`define SMC_LINES_1 12'd192
`define SMC_LINES_2 12'd200
`define SMC_LINES_3 12'd400
`define SMC_LINES_4 12'd512
`define SMC_LINES_5 12'd1000
`define SMC_LINES_6 12'd1024
`define SMC_LINES_7 12'd2000
`define SMC_LINES_8 12'd2048
// ==========================================================
// status byte fields and reset values
`define SMC_ST_READY 0
`define SMC_ST_POS_ERR 1
`define SMC_ST_DIR 2
`define SMC_IDLE_CUR_RST 7'd25
`define SMC_RUN_CUR_RST 7'd50
`define SMC_CUR_MAX 7'd100
`endif

// *** include/smc_pkg.sv ***
// types shared by the stepper settings core and its encoder decoder
// assumes smc_params.svh on the include path
package smc_pkg;
`include "smc_params.svh"

  // ==========================================================
  // configuration carried as one group
  typedef struct packed {
    logic [3:0] step_mode;
    logic [2:0] angle_sel;
    logic [3:0] lines_sel;
    logic [6:0] run_cur;
    logic [6:0] idle_cur;
    logic [15:0] backlash;
    logic enc_swap;
    logic auto_status;
  } smc_cfg_s;

  typedef enum logic {SMC_IDLE, SMC_RUN} smc_state_e;
endpackage

// *** core/smc_quad.sv ***
// quadrature decoder with track swap, four counts per encoder line
// assumes raw encoder tracks from pins, one system clock
`timescale 1ns/100ps
module smc_quad import smc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic a_pin,
  input wire logic b_pin,
  input wire logic swap,
  output logic signed [31:0] count
);
  logic [1:0] a_sync_reg, b_sync_reg;
  logic a_prev_reg, b_prev_reg;
  logic a_now, b_now;

  // ==========================================================
  // two-stage synchronisers; only stage two is read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a_sync_reg <= 2'h0;
      b_sync_reg <= 2'h0;
    end else begin
      a_sync_reg <= {a_sync_reg[0], a_pin};
      b_sync_reg <= {b_sync_reg[0], b_pin};
    end
  end

  // swap tracks ahead of decoding so direction sense flips
  assign a_now = swap ? b_sync_reg[1] : a_sync_reg[1];
  assign b_now = swap ? a_sync_reg[1] : b_sync_reg[1];

  // ==========================================================
  // one count per edge; a double change is illegal and ignored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      count <= 32'sh0;
    end else begin
      a_prev_reg <= a_now;
      b_prev_reg <= b_now;
      if ((a_now ^ a_prev_reg) != (b_now ^ b_prev_reg)) begin
        if (a_now ^ b_prev_reg)
          count <= count + 32'sh1;
        else
          count <= count - 32'sh1;
      end
    end
  end
endmodule

// *** core/smc_core.sv ***
// stepper settings core: step generation, currents, backlash, encoder check
// assumes synchronous command inputs from the host side logic, encoder on pins
`timescale 1ns/100ps
`include "smc_params.svh"
module smc_core import smc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire smc_cfg_s cfg,
  input wire logic move_start,
  input wire logic move_dir,
  input wire logic [23:0] move_count,
  input wire logic [15:0] move_speed,
  input wire logic enc_a_pin,
  input wire logic enc_b_pin,
  output logic step_out,
  output logic dir_out,
  output logic [6:0] phase_cur_pct,
  output logic run_busy,
  output logic pos_err,
  output logic status_valid,
  output logic [7:0] status_byte,
  output logic signed [31:0] cmd_pos,
  output logic signed [31:0] enc_count
);
  smc_cfg_s cfg_reg;
  smc_state_e state_reg;
  logic [24:0] rem_reg;
  logic [25:0] acc_reg;
  logic [15:0] speed_reg;
  logic [3:0] frac_reg;
  logic last_dir_reg;
  logic signed [47:0] cmd_scl_reg, enc_scl_reg;
  logic signed [31:0] enc_raw;
  logic adaptive;
  logic [6:0] eff_div, dec, pos_q, pos_add;
  logic [3:0] pos_r;
  logic [4:0] frac_sum;
  logic [25:0] acc_sum;
  logic tick;
  logic [8:0] spr;
  logic [13:0] edges_rev;
  logic [24:0] total;
  logic signed [47:0] dev;
  logic signed [47:0] err_lim;
  logic [6:0] ad_div;
  logic [10:0] ad_units, units;
  logic carry;

  // ==========================================================
  // decoding tables
  function automatic logic [6:0] div_of(input logic [3:0] mode);
    case (mode)
      `SMC_MODE_HALF: div_of = 7'h02;
      `SMC_MODE_QUARTER: div_of = 7'h04;
      `SMC_MODE_FIFTH: div_of = 7'h05;
      `SMC_MODE_EIGHTH: div_of = 7'h08;
      `SMC_MODE_TENTH: div_of = 7'h0a;
      `SMC_MODE_16TH: div_of = 7'h10;
      `SMC_MODE_32ND: div_of = 7'h20;
      `SMC_MODE_64TH: div_of = 7'h40;
      default: div_of = 7'h01;
    endcase
  endfunction

  // 64th units per pulse; fifth and tenth leave a remainder in frac_reg
  function automatic logic [10:0] units_of(input logic [6:0] div);
    case (div)
      7'h02: units_of = {7'h20, 4'h0};
      7'h04: units_of = {7'h10, 4'h0};
      7'h05: units_of = {7'h0c, 4'h4};
      7'h08: units_of = {7'h08, 4'h0};
      7'h0a: units_of = {7'h06, 4'h4};
      7'h10: units_of = {7'h04, 4'h0};
      7'h20: units_of = {7'h02, 4'h0};
      7'h40: units_of = {7'h01, 4'h0};
      default: units_of = {`SMC_UNITS_PER_FULL, 4'h0};
    endcase
  endfunction

  function automatic logic [8:0] spr_of(input logic [2:0] sel);
    case (sel)
      3'h1: spr_of = `SMC_SPR_0P9;
      3'h2: spr_of = `SMC_SPR_3P6;
      3'h3: spr_of = `SMC_SPR_7P5;
      3'h4: spr_of = `SMC_SPR_15;
      default: spr_of = `SMC_SPR_1P8;
    endcase
  endfunction

  function automatic logic [11:0] lines_of(input logic [3:0] sel);
    case (sel)
      4'h1: lines_of = `SMC_LINES_1;
      4'h2: lines_of = `SMC_LINES_2;
      4'h3: lines_of = `SMC_LINES_3;
      4'h4: lines_of = `SMC_LINES_4;
      4'h5: lines_of = `SMC_LINES_5;
      4'h6: lines_of = `SMC_LINES_6;
      4'h7: lines_of = `SMC_LINES_7;
      4'h8: lines_of = `SMC_LINES_8;
      default: lines_of = `SMC_LINES_0;
    endcase
  endfunction

  // rpm compare without division: speed*60 against threshold*steps per rev
  function automatic logic [6:0] adapt_div(input logic [15:0] spd, input logic [8:0] s);
    logic [23:0] v;
    v = 24'(spd) * 24'(`SMC_SEC_PER_MIN);
    if (v < 24'(`SMC_RPM_T64 * s)) adapt_div = 7'h40;
    else if (v < 24'(`SMC_RPM_T32 * s)) adapt_div = 7'h20;
    else if (v < 24'(`SMC_RPM_T16 * s)) adapt_div = 7'h10;
    else if (v < 24'(`SMC_RPM_T8 * s)) adapt_div = 7'h08;
    else if (v < 24'(`SMC_RPM_T4 * s)) adapt_div = 7'h04;
    else if (v < 24'(`SMC_RPM_T2 * s)) adapt_div = 7'h02;
    else adapt_div = 7'h01;
  endfunction

  // ==========================================================
  // step size selection and pulse rate
  assign spr = spr_of(cfg_reg.angle_sel);
  assign adaptive = (cfg_reg.step_mode == `SMC_MODE_ADAPT);
  assign ad_div = adapt_div(speed_reg, spr);
  assign ad_units = units_of(ad_div);
  always_comb begin
    eff_div = div_of(cfg_reg.step_mode);
    dec = 7'h01;
    if (adaptive) begin
      eff_div = ad_div;
      dec = ad_units[10:4];
      // near the end fall back to 64th so the move lands exactly
      if (25'(dec) > rem_reg) begin
        eff_div = 7'h40;
        dec = 7'h01;
      end
    end
  end
  assign units = units_of(eff_div);
  assign pos_q = adaptive ? dec : units[10:4];
  assign pos_r = adaptive ? 4'h0 : units[3:0];
  assign frac_sum = {1'b0, frac_reg} + {1'b0, pos_r};
  // only fifth and tenth carry a remainder; 32nd and 64th would see a false carry
  assign carry = (pos_r != 4'h0) && (frac_sum >= eff_div[4:0]);
  assign pos_add = pos_q + (carry ? 7'h01 : 7'h00);
  // phase accumulator avoids a divider; rate is full steps/s times divisor
  assign acc_sum = acc_reg + {3'h0, 23'(speed_reg * eff_div)};
  assign tick = (state_reg == SMC_RUN) && (acc_sum >= `SMC_CLK_HZ);
  assign total = {1'b0, move_count} +
    ((move_dir != last_dir_reg) ? {9'h0, cfg.backlash} : 25'h0);

  // ==========================================================
  // configuration shadow, frozen during a run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= '{step_mode: `SMC_MODE_FULL, angle_sel: `SMC_ANGLE_1P8,
        lines_sel: 4'h0, run_cur: `SMC_RUN_CUR_RST, idle_cur: `SMC_IDLE_CUR_RST,
        backlash: 16'h0, enc_swap: 1'b0, auto_status: 1'b0};
    end else if (state_reg == SMC_IDLE) begin
      cfg_reg <= cfg;
    end
  end

  // ==========================================================
  // run sequencing and step pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= SMC_IDLE;
      rem_reg <= 25'h0;
      acc_reg <= 26'h0;
      speed_reg <= 16'h0;
      last_dir_reg <= 1'b1;
      dir_out <= 1'b1;
      step_out <= 1'b0;
      run_busy <= 1'b0;
    end else begin
      step_out <= 1'b0;
      case (state_reg)
        SMC_IDLE: begin
          acc_reg <= 26'h0;
          if (move_start && total != 25'h0) begin
            state_reg <= SMC_RUN;
            rem_reg <= total;
            speed_reg <= move_speed;
            dir_out <= move_dir;
            last_dir_reg <= move_dir;
            run_busy <= 1'b1;
          end
        end
        SMC_RUN: begin
          acc_reg <= tick ? acc_sum - `SMC_CLK_HZ : acc_sum;
          if (tick) begin
            step_out <= 1'b1;
            rem_reg <= rem_reg - 25'(dec);
            if (rem_reg == 25'(dec)) begin
              state_reg <= SMC_IDLE;
              run_busy <= 1'b0;
            end
          end
        end
        default: state_reg <= SMC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // commanded position in 64th units, remainder for fifth and tenth
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_pos <= 32'sh0;
      frac_reg <= 4'h0;
    end else if (state_reg == SMC_IDLE && move_start) begin
      frac_reg <= 4'h0;
    end else if (tick) begin
      frac_reg <= carry ? 4'(frac_sum - eff_div[4:0]) : frac_sum[3:0];
      if (dir_out)
        cmd_pos <= cmd_pos + 32'(pos_add);
      else
        cmd_pos <= cmd_pos - 32'(pos_add);
    end
  end

  // ==========================================================
  // phase current: run value while moving, standstill value otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_cur_pct <= `SMC_IDLE_CUR_RST;
    end else if (state_reg == SMC_RUN) begin
      phase_cur_pct <= (cfg_reg.run_cur > `SMC_CUR_MAX) ? `SMC_CUR_MAX : cfg_reg.run_cur;
    end else begin
      phase_cur_pct <= (cfg_reg.idle_cur > `SMC_CUR_MAX) ? `SMC_CUR_MAX : cfg_reg.idle_cur;
    end
  end

  // ==========================================================
  // encoder and deviation check in a common scale, two pipeline stages
  smc_quad u_quad (
    .clk_sys(clk_sys),
    .rst(rst),
    .a_pin(enc_a_pin),
    .b_pin(enc_b_pin),
    .swap(cfg_reg.enc_swap),
    .count(enc_raw)
  );
  assign edges_rev = {lines_of(cfg_reg.lines_sel), 2'h0};
  assign dev = cmd_scl_reg - enc_scl_reg;
  // signed limit, so an encoder running ahead is not read as a huge deviation
  assign err_lim = 48'(`SMC_HALF_STEP_UNITS * 20'(edges_rev));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_scl_reg <= 48'sh0;
      enc_scl_reg <= 48'sh0;
      enc_count <= 32'sh0;
      pos_err <= 1'b0;
    end else begin
      enc_count <= enc_raw;
      cmd_scl_reg <= 48'(cmd_pos * $signed({1'b0, edges_rev}));
      enc_scl_reg <= 48'(enc_raw * $signed({1'b0, `SMC_UNITS_PER_FULL * 16'(spr)}));
      pos_err <= (dev > err_lim) || (-dev > err_lim);
    end
  end

  // ==========================================================
  // unprompted status at run end; host must keep it off on a shared bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_valid <= 1'b0;
      status_byte <= 8'h0;
    end else begin
      status_valid <= 1'b0;
      if (tick && rem_reg == 25'(dec) && cfg_reg.auto_status) begin
        status_valid <= 1'b1;
        status_byte <= 8'h0;
        status_byte[`SMC_ST_READY] <= 1'b1;
        status_byte[`SMC_ST_POS_ERR] <= pos_err;
        status_byte[`SMC_ST_DIR] <= dir_out;
      end
    end
  end
endmodule

// *** verification/smc_core_checker.sv ***
// checker for the stepper settings core: outputs tied to commands and settings
// assumes binding onto smc_core, one clock, asynchronous active-high reset
`timescale 1ns/100ps
`include "smc_params.svh"
module smc_core_checker import smc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire smc_cfg_s cfg,
  input wire logic move_start,
  input wire logic [23:0] move_count,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic [6:0] phase_cur_pct,
  input wire logic run_busy,
  input wire logic pos_err,
  input wire logic status_valid,
  input wire logic [7:0] status_byte,
  input wire logic signed [31:0] cmd_pos
);
  logic [3:0] mode_reg;
  logic [6:0] run_reg;
  logic auto_reg;

  function automatic logic [6:0] unit_of(logic [3:0] m);
    case (m)
      4'h0: return 7'h40;
      4'h1: return 7'h20;
      4'h2: return 7'h10;
      4'h4: return 7'h08;
      4'h6: return 7'h04;
      4'h7: return 7'h02;
      4'h8: return 7'h01;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [6:0] clamp(logic [6:0] v);
    return (v > `SMC_CUR_MAX) ? `SMC_CUR_MAX : v;
  endfunction

  // ==========================================================
  // settings as frozen at run start; the last idle edge is the taking edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg <= `SMC_MODE_FULL;
      run_reg <= `SMC_RUN_CUR_RST;
      auto_reg <= 1'b0;
    end else if (!run_busy) begin
      mode_reg <= cfg.step_mode;
      run_reg <= cfg.run_cur;
      auto_reg <= cfg.auto_status;
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_start_busy: assert property ((move_start && !run_busy && move_count != 24'h0) |=> run_busy)
    else $error("accepted move did not start a run");
  a_busy_cause: assert property ($rose(run_busy) |-> $past(move_start))
    else $error("run began without a start command");
  a_step_in_run: assert property (step_out |-> (run_busy || $past(run_busy)))
    else $error("step pulse outside a run");
  a_step_size: assert property ((step_out && unit_of(mode_reg) != 7'h00) |->
      (cmd_pos - $past(cmd_pos)) == (dir_out ? 32'(unit_of(mode_reg)) : -32'(unit_of(mode_reg))))
    else $error("position step does not match step mode");
  a_run_cur: assert property ((run_busy && $past(run_busy)) |-> phase_cur_pct == clamp(run_reg))
    else $error("running current wrong");
  a_idle_cur: assert property ((!run_busy && !$past(run_busy) && !$past(run_busy, 2) &&
      !$past(rst) && !$past(rst, 2)) |-> phase_cur_pct == clamp($past(cfg.idle_cur, 2)))
    else $error("standstill current wrong");
  a_dir_hold: assert property ((run_busy && $past(run_busy)) |-> $stable(dir_out))
    else $error("direction changed inside a run");
  a_status_end: assert property (status_valid |-> ($fell(run_busy) && auto_reg && status_byte[0]))
    else $error("status byte sent outside a run end");
  a_status_byte: assert property (status_valid |->
      (status_byte[2] == dir_out && status_byte[1] == $past(pos_err)))
    else $error("status byte fields wrong");
endmodule

// *** verification/smc_motor_model.sv ***
// motor and encoder stand-in: the shaft follows the commanded position
// assumes one system clock; the encoder moves one edge per cycle, so it lags
`timescale 1ns/100ps
module smc_motor_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic signed [31:0] cmd_pos,
  input wire logic [15:0] lines4,
  input wire logic [15:0] spr,
  output logic enc_a_pin,
  output logic enc_b_pin
);
  int target;
  int cnt_reg;

  // ==========================================================
  // shaft target in encoder edges for the present line count and motor
  always_comb begin
    target = int'(cmd_pos) * int'(lines4) / (64 * int'(spr));
  end

  // slew one edge a cycle; a lagging shaft is what a real rotor gives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 0;
    end else if (cnt_reg < target) begin
      cnt_reg <= cnt_reg + 1;
    end else if (cnt_reg > target) begin
      cnt_reg <= cnt_reg - 1;
    end
  end

  // gray phases 00,10,11,01: track a leads b when counting up
  assign enc_a_pin = cnt_reg[1] ^ cnt_reg[0];
  assign enc_b_pin = cnt_reg[1];
endmodule

// *** verification/testbench.sv ***
// self-checking bench: moves in every mode and line count, on 15 and 1.8 degree motors
// assumes smc_core, the motor model and the checker; 20 MHz clock
`timescale 1ns/100ps
module testbench import smc_pkg::*;;
  logic clk_sys, rst, move_start, move_dir, enc_a_pin, enc_b_pin;
  smc_cfg_s cfg;
  logic [23:0] move_count;
  logic [15:0] move_speed, lines4, spr;
  logic step_out, dir_out, run_busy, pos_err, status_valid;
  logic [6:0] phase_cur_pct;
  logic [7:0] status_byte;
  logic signed [31:0] cmd_pos, enc_count;
  int error_cnt, comparisons, pulses, stats, cycles, exp_pos;
  int lines_tab[9] = '{500, 192, 200, 400, 512, 1000, 1024, 2000, 2048};
  int div_tab[9] = '{1, 2, 4, 5, 8, 10, 16, 32, 64};

  smc_core i_dut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .move_start(move_start),
    .move_dir(move_dir), .move_count(move_count), .move_speed(move_speed),
    .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin), .step_out(step_out), .dir_out(dir_out),
    .phase_cur_pct(phase_cur_pct), .run_busy(run_busy), .pos_err(pos_err),
    .status_valid(status_valid), .status_byte(status_byte), .cmd_pos(cmd_pos),
    .enc_count(enc_count));
  smc_motor_model i_motor (.clk_sys(clk_sys), .rst(rst), .cmd_pos(cmd_pos), .lines4(lines4),
    .spr(spr), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin));

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic int encx(int p);
    return p * int'(lines4) / (64 * int'(spr));
  endfunction

  // bounded wait for the encoder to reach a count worked out here
  task automatic wait_enc(input int e);
    int n;
    n = 0;
    while (enc_count !== e && n < 10000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(enc_count === e, "encoder count");
  endtask

  // one move; poke alters settings mid-run, which must not take effect
  task automatic move(input logic d, input int cnt, input int spd, input int np, input int dp,
      input bit poke);
    int p0, s0;
    smc_cfg_s keep;
    p0 = pulses;
    s0 = stats;
    keep = cfg;
    move_dir = d;
    move_count = 24'(cnt);
    move_speed = 16'(spd);
    move_start = 1'b1;
    @(negedge clk_sys);
    move_start = 1'b0;
    chk(run_busy === 1'b1, "run not started");
    repeat (2) @(negedge clk_sys);
    chk(phase_cur_pct === cfg.run_cur, "run current");
    if (poke) begin
      cfg.step_mode = 4'h8;
      cfg.run_cur = 7'h5a;
      repeat (2) @(negedge clk_sys);
      chk(phase_cur_pct === keep.run_cur, "current changed in run");
    end
    while (run_busy !== 1'b0) @(negedge clk_sys);
    cfg = keep;
    exp_pos += dp;
    repeat (3) @(negedge clk_sys);
    chk(pulses - p0 == np, "pulse count");
    chk(cmd_pos === exp_pos, "position");
    chk(dir_out === d, "direction");
    chk(stats - s0 == int'(cfg.auto_status), "status pulses");
    chk(phase_cur_pct === cfg.idle_cur, "idle current");
  endtask

  task automatic settle;
    wait_enc(encx(exp_pos));
    repeat (2) @(negedge clk_sys);
    chk(pos_err === 1'b0, "false position error");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // monitor and watchdog at the falling edge, where outputs are settled
  always @(negedge clk_sys) begin
    cycles++;
    if (step_out === 1'b1) pulses++;
    if (status_valid === 1'b1) begin
      stats++;
      chk(status_byte[0] === 1'b1 && status_byte[2] === dir_out, "status byte");
    end
    if (cycles == 90000) begin
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      results();
    end
  end

  initial begin
    rst = 1'b1;
    cfg = '{step_mode: 4'h0, angle_sel: 3'h4, lines_sel: 4'h0, run_cur: 7'h3c,
      idle_cur: 7'h1e, backlash: 16'h0, enc_swap: 1'b0, auto_status: 1'b0};
    move_start = 1'b0;
    move_dir = 1'b1;
    move_count = 24'h0;
    move_speed = 16'h0;
    lines4 = 16'h07d0;
    spr = 16'h0018;
    repeat (5) @(negedge clk_sys);
    chk(dir_out === 1'b1 && phase_cur_pct === 7'h19 && run_busy === 1'b0, "reset");
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(phase_cur_pct === 7'h1e, "standstill current");
    // every line count on a 15 degree motor: three steps are an eighth turn
    for (int i = 0; i < 9; i++) begin
      cfg.lines_sel = 4'(i);
      lines4 = 16'(4 * lines_tab[i]);
      @(negedge clk_sys);
      move(1'b1, 3, 50000, 3, 192, 1'b0);
      settle();
    end
    cfg.angle_sel = 3'h0;
    cfg.lines_sel = 4'h0;
    spr = 16'h00c8;
    lines4 = 16'h07d0;
    repeat (3) @(negedge clk_sys);
    settle();
    // each fixed resolution moves one full step
    for (int m = 0; m < 9; m++) begin
      cfg.step_mode = 4'(m);
      @(negedge clk_sys);
      move(1'b1, div_tab[m], 20000, div_tab[m], 64, m == 0);
      settle();
    end
    cfg.step_mode = 4'h9;
    @(negedge clk_sys);
    move(1'b1, 130, 10000, 4, 130, 1'b0);
    move(1'b1, 16, 1000, 2, 16, 1'b0);
    settle();
    cfg.step_mode = 4'h0;
    cfg.backlash = 16'h3;
    @(negedge clk_sys);
    move(1'b0, 2, 20000, 5, -320, 1'b0);
    move(1'b0, 2, 20000, 2, -128, 1'b0);
    move(1'b1, 0, 20000, 3, 192, 1'b0);
    settle();
    cfg.auto_status = 1'b1;
    @(negedge clk_sys);
    move(1'b1, 1, 20000, 1, 64, 1'b0);
    cfg.auto_status = 1'b0;
    settle();
    // swapped tracks on a plain encoder: the count runs backwards
    cfg.enc_swap = 1'b1;
    repeat (3) @(negedge clk_sys);
    move(1'b1, 1, 20000, 1, 64, 1'b0);
    wait_enc(342);
    chk(pos_err === 1'b1, "missed position error");
    results();
  end
endmodule

bind smc_core smc_core_checker i_chk (.clk_sys(clk_sys), .rst(rst), .cfg(cfg),
  .move_start(move_start), .move_count(move_count), .step_out(step_out), .dir_out(dir_out),
  .phase_cur_pct(phase_cur_pct), .run_busy(run_busy), .pos_err(pos_err),
  .status_valid(status_valid), .status_byte(status_byte), .cmd_pos(cmd_pos));
